//--- core/ufb_uart.sv
`timescale 1ns/1ns
`default_nettype none
module ufb_uart
  import ufb_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SIN,
  output logic SOUT,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic RI_N,
  input wire logic DCD_N,
  output logic RTS_N,
  output logic DTR_N,
  output logic IRQ,
  output logic DMA_MODE
);
  typedef enum logic [1:0] {UFB_RX_IDLE, UFB_RX_START, UFB_RX_BITS} ufb_rx_t;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: reads act in the address phase, writes in the data phase
  logic wr_q;
  logic [7:0] wa_q;
  logic [7:0] ier_q;
  logic [7:0] dll_q;
  logic [7:0] dlm_q;
  logic [7:0] lcr_q;
  logic [4:0] hc_q;
  logic [7:0] scr_q;
  logic [2:0] cfg_q;
  logic fifo_en_q;
  logic [1:0] thr_sel_q;
  logic dma_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  logic [7:0] rdata_d;

  wire ad_ok = HSEL && HTRANS[1] && HREADY;
  wire rd_en = ad_ok && !HWRITE;
  wire [7:0] ra = HADDR[7:0];
  wire [7:0] wd = HWDATA[7:0];
  wire dlab = lcr_q[UFB_LC_DLAB];
  wire loop = hc_q[UFB_HC_LOOP];

  wire w_data = wr_q && wa_q == UFB_A_DATA && !dlab;
  wire w_dll = wr_q && wa_q == UFB_A_DATA && dlab;
  wire w_ier = wr_q && wa_q == UFB_A_IER && !dlab;
  wire w_dlm = wr_q && wa_q == UFB_A_IER && dlab;
  wire w_fcr = wr_q && wa_q == UFB_A_IIR;
  wire w_lcr = wr_q && wa_q == UFB_A_LCR;
  wire w_hc = wr_q && wa_q == UFB_A_HC;
  wire w_scr = wr_q && wa_q == UFB_A_SCR;
  wire w_cfg = wr_q && wa_q == UFB_A_CFG;
  wire r_data = rd_en && ra == UFB_A_DATA && !dlab;
  wire r_iir = rd_en && ra == UFB_A_IIR;
  wire r_lsr = rd_en && ra == UFB_A_LSR;
  wire r_hsr = rd_en && ra == UFB_A_HSR;

  // flipping the mode bit also flushes both fifos, so stale bytes never leak
  wire mode_flip = w_fcr && (wd[UFB_FC_FIFO_EN] != fifo_en_q);
  wire tx_clr = w_fcr && (wd[UFB_FC_TX_CLR] || mode_flip);
  wire rx_clr = w_fcr && (wd[UFB_FC_RX_CLR] || mode_flip);

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else begin
      wr_q <= ad_ok && HWRITE;
      wa_q <= ra;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ier_q <= UFB_RST_BYTE;
      dll_q <= UFB_RST_BYTE;
      dlm_q <= UFB_RST_BYTE;
      lcr_q <= UFB_RST_BYTE;
      hc_q <= 5'h00;
      scr_q <= UFB_RST_BYTE;
      cfg_q <= UFB_RST_CFG;
    end else begin
      if (w_ier) ier_q <= {4'h0, wd[3:0]};
      if (w_dll) dll_q <= wd;
      if (w_dlm) dlm_q <= wd;
      if (w_lcr) lcr_q <= wd;
      if (w_hc) hc_q <= wd[4:0];
      if (w_scr) scr_q <= wd;
      if (w_cfg) cfg_q <= wd[2:0];
    end
  end

  // mode bit is taken from the same write, so a write that sets fifo mode
  // and other bits together behaves as software is told to do it
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      fifo_en_q <= 1'b0;
      thr_sel_q <= 2'h0;
      dma_q <= 1'b0;
    end else if (w_fcr) begin
      fifo_en_q <= wd[UFB_FC_FIFO_EN];
      thr_sel_q <= wd[UFB_FC_THR+1:UFB_FC_THR];
      dma_q <= wd[UFB_FC_DMA];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generator and fifos
  logic tick;
  logic [7:0] tx_dout;
  logic [4:0] tx_cnt;
  logic [7:0] rx_dout;
  logic [4:0] rx_cnt;
  logic tx_busy_q;
  logic rx_done_q;
  logic [8:0] rx_sh_q;

  ufb_baudgen u_baud (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .prediv_sel(cfg_q[1:0]),
    .high_speed(cfg_q[UFB_CF_HISPEED]),
    .divisor({dlm_q, dll_q}),
    .tick16(tick)
  );

  // without fifo mode each fifo acts as a single holding buffer
  wire tx_empty = tx_cnt == 5'h00;
  wire rx_empty = rx_cnt == 5'h00;
  wire tx_full = fifo_en_q ? tx_cnt == UFB_FIFO_FULL : !tx_empty;
  wire rx_full = fifo_en_q ? rx_cnt == UFB_FIFO_FULL : !rx_empty;
  wire tx_load = tick && !tx_busy_q && !tx_empty;
  wire rx_push = rx_done_q && !rx_full;
  wire rx_pop = r_data && !rx_empty;

  ufb_fifo u_txf (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .clr(tx_clr),
    .push(w_data && !tx_full),
    .din(wd),
    .pop(tx_load),
    .dout(tx_dout),
    .count(tx_cnt)
  );

  ufb_fifo u_rxf (
    .clk(CLK_SYS),
    .rst_n(RESET_N),
    .clr(rx_clr),
    .push(rx_push),
    .din(rx_sh_q[7:0]),
    .pop(rx_pop),
    .dout(rx_dout),
    .count(rx_cnt)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmitter: fixed 8 data bits, no parity, one stop bit
  logic [9:0] tx_sh_q;
  logic [3:0] tx_sub_q;
  logic [3:0] tx_bit_q;
  wire tx_line = tx_busy_q ? tx_sh_q[0] : 1'b1;

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N || tx_clr) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3ff;
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      tx_sh_q <= {1'b1, tx_dout, 1'b0};
      tx_sub_q <= 4'h0;
      tx_bit_q <= 4'h0;
    end else if (tick && tx_busy_q) begin
      tx_sub_q <= tx_sub_q + 4'h1;
      if (tx_sub_q == 4'hf) begin
        tx_sh_q <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        tx_busy_q <= tx_bit_q != 4'(UFB_CHAR_BITS - 1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receiver: start bit checked mid-bit, then one sample per bit time
  ufb_rx_t rx_st_q;
  logic [3:0] rx_sub_q;
  logic [3:0] rx_bit_q;
  wire rx_in = loop ? tx_line : SIN;
  wire rx_last = tick && rx_st_q == UFB_RX_BITS && rx_sub_q == 4'hf &&
    rx_bit_q == 4'h8;

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      rx_st_q <= UFB_RX_IDLE;
      rx_sub_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
    end else if (tick) begin
      rx_sub_q <= rx_sub_q + 4'h1;
      case (rx_st_q)
        UFB_RX_IDLE: begin
          rx_sub_q <= 4'h0;
          if (!rx_in) rx_st_q <= UFB_RX_START;
        end
        UFB_RX_START: begin
          if (rx_sub_q == 4'h7) begin
            rx_st_q <= rx_in ? UFB_RX_IDLE : UFB_RX_BITS;
            rx_sub_q <= 4'h0;
            rx_bit_q <= 4'h0;
          end
        end
        default: begin
          if (rx_sub_q == 4'hf) begin
            rx_sh_q <= {rx_in, rx_sh_q[8:1]};
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == 4'h8) rx_st_q <= UFB_RX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= rx_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line status events; a new event beats a clearing read
  logic ovr_q;
  logic stp_q;
  logic brk_q;
  wire stop_bad = !rx_sh_q[8];
  wire brk_set = rx_done_q && stop_bad && rx_sh_q[7:0] == 8'h00;

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      ovr_q <= 1'b0;
      stp_q <= 1'b0;
      brk_q <= 1'b0;
    end else begin
      ovr_q <= (rx_done_q && rx_full) || (ovr_q && !r_lsr);
      stp_q <= (rx_done_q && stop_bad) || (stp_q && !r_lsr);
      brk_q <= brk_set || (brk_q && !r_lsr);
    end
  end

  // idle counter restarts on every fifo access and while the fifo is empty
  logic [9:0] to_cnt_q;
  wire to_hit = to_cnt_q == UFB_TIMEOUT_TICKS;

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N || rx_push || rx_pop || rx_empty || !fifo_en_q) begin
      to_cnt_q <= 10'h000;
    end else if (tick && !to_hit) begin
      to_cnt_q <= to_cnt_q + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake inputs and change flags
  logic [3:0] hs_prev_q;
  logic [3:0] hs_delta_q;
  wire [3:0] hs_now = loop ? {hc_q[3], hc_q[2], hc_q[0], hc_q[1]} :
    {!DCD_N, !RI_N, !DSR_N, !CTS_N};
  wire [3:0] hs_evt;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_hs
      // ring reports only its trailing edge, the others any change
      if (gi == 2) begin : g_ring
        assign hs_evt[gi] = hs_prev_q[gi] && !hs_now[gi];
      end else begin : g_chg
        assign hs_evt[gi] = hs_prev_q[gi] != hs_now[gi];
      end
      always_ff @(posedge CLK_SYS) begin
        if (!RESET_N) begin
          hs_delta_q[gi] <= 1'b0;
        end else begin
          hs_delta_q[gi] <= hs_evt[gi] || (hs_delta_q[gi] && !r_hsr);
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      hs_prev_q <= 4'h0;
    end else begin
      hs_prev_q <= hs_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt prioritisation
  logic thre_q;
  logic [3:0] iid;
  wire [4:0] thr = thr_sel_q == 2'h0 ? UFB_THR_0 :
    thr_sel_q == 2'h1 ? UFB_THR_1 :
    thr_sel_q == 2'h2 ? UFB_THR_2 : UFB_THR_3;
  wire ls_pend = ier_q[2] && (ovr_q || stp_q || brk_q);
  wire rd_pend = ier_q[0] && (fifo_en_q ? rx_cnt >= thr : !rx_empty);
  wire to_pend = ier_q[0] && fifo_en_q && to_hit && !rx_empty;
  wire tx_pend = ier_q[1] && thre_q;
  wire ms_pend = ier_q[3] && (hs_delta_q != 4'h0);
  wire any_pend = ls_pend || rd_pend || to_pend || tx_pend || ms_pend;

  assign iid = ls_pend ? UFB_IID_LS :
    rd_pend ? UFB_IID_RD :
    to_pend ? UFB_IID_TO :
    tx_pend ? UFB_IID_TX :
    ms_pend ? UFB_IID_MS : UFB_IID_NONE;
  wire [7:0] iir = {fifo_en_q, fifo_en_q, 2'b00, iid};

  // empty flag rises when the last byte leaves; set beats clear
  wire thre_set = (tx_load && tx_cnt == 5'h01) || tx_clr;
  wire thre_clr = w_data || (r_iir && iid == UFB_IID_TX);

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      thre_q <= 1'b1;
    end else begin
      thre_q <= thre_set || (thre_q && !thre_clr);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data and registered outputs
  wire [7:0] lsr = {1'b0, tx_empty && !tx_busy_q, tx_empty, brk_q, stp_q,
    1'b0, ovr_q, !rx_empty};

  always_comb begin
    if (ra == UFB_A_DATA) begin
      rdata_d = dlab ? dll_q : rx_dout;
    end else if (ra == UFB_A_IER) begin
      rdata_d = dlab ? dlm_q : ier_q;
    end else if (ra == UFB_A_IIR) begin
      rdata_d = iir;
    end else if (ra == UFB_A_LCR) begin
      rdata_d = lcr_q;
    end else if (ra == UFB_A_HC) begin
      rdata_d = {3'h0, hc_q};
    end else if (ra == UFB_A_LSR) begin
      rdata_d = lsr;
    end else if (ra == UFB_A_HSR) begin
      rdata_d = {hs_now, hs_delta_q};
    end else if (ra == UFB_A_SCR) begin
      rdata_d = scr_q;
    end else if (ra == UFB_A_CFG) begin
      rdata_d = {5'h00, cfg_q};
    end else begin
      rdata_d = 8'h00;
    end
  end

  logic sout_q;
  logic rts_n_q;
  logic dtr_n_q;
  logic irq_q;
  logic dma_mode_q;

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      hrdata_q <= 32'h00000000;
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      sout_q <= 1'b1;
      rts_n_q <= 1'b1;
      dtr_n_q <= 1'b1;
      irq_q <= 1'b0;
      dma_mode_q <= 1'b0;
    end else begin
      if (rd_en) hrdata_q <= {24'h000000, rdata_d};
      hreadyout_q <= 1'b1;
      hresp_q <= 1'b0;
      sout_q <= loop || tx_line;
      rts_n_q <= loop || !hc_q[1];
      dtr_n_q <= loop || !hc_q[0];
      irq_q <= any_pend && hc_q[UFB_HC_IRQ_EN];
      dma_mode_q <= fifo_en_q && dma_q;
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = hreadyout_q;
  assign HRESP = hresp_q;
  assign SOUT = sout_q;
  assign RTS_N = rts_n_q;
  assign DTR_N = dtr_n_q;
  assign IRQ = irq_q;
  assign DMA_MODE = dma_mode_q;
endmodule // ufb_uart
`default_nettype wire

//--- core/ufb_pkg.sv
package ufb_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] UFB_A_DATA = 8'h00;
  localparam logic [7:0] UFB_A_IER = 8'h04;
  localparam logic [7:0] UFB_A_IIR = 8'h08;
  localparam logic [7:0] UFB_A_LCR = 8'h0c;
  localparam logic [7:0] UFB_A_HC = 8'h10;
  localparam logic [7:0] UFB_A_LSR = 8'h14;
  localparam logic [7:0] UFB_A_HSR = 8'h18;
  localparam logic [7:0] UFB_A_SCR = 8'h1c;
  localparam logic [7:0] UFB_A_CFG = 8'h20;
  // field positions
  localparam int UFB_FC_FIFO_EN = 0;
  localparam int UFB_FC_RX_CLR = 1;
  localparam int UFB_FC_TX_CLR = 2;
  localparam int UFB_FC_DMA = 3;
  localparam int UFB_FC_THR = 6;
  localparam int UFB_LC_DLAB = 7;
  localparam int UFB_HC_IRQ_EN = 3;
  localparam int UFB_HC_LOOP = 4;
  localparam int UFB_CF_HISPEED = 2;
  // interrupt identification codes
  localparam logic [3:0] UFB_IID_NONE = 4'h1;
  localparam logic [3:0] UFB_IID_LS = 4'h6;
  localparam logic [3:0] UFB_IID_RD = 4'h4;
  localparam logic [3:0] UFB_IID_TO = 4'hc;
  localparam logic [3:0] UFB_IID_TX = 4'h2;
  localparam logic [3:0] UFB_IID_MS = 4'h0;
  // receive thresholds in bytes
  localparam logic [4:0] UFB_THR_0 = 5'h01;
  localparam logic [4:0] UFB_THR_1 = 5'h04;
  localparam logic [4:0] UFB_THR_2 = 5'h08;
  localparam logic [4:0] UFB_THR_3 = 5'h0e;
  // reset values
  localparam logic [7:0] UFB_RST_BYTE = 8'h00;
  localparam logic [2:0] UFB_RST_CFG = 3'h0;
  // fifo shape
  localparam int UFB_FIFO_DEPTH = 16;
  localparam int UFB_FIFO_AW = 4;
  localparam logic [4:0] UFB_FIFO_FULL = 5'h10;
  // timing
  localparam int UFB_CLK_MHZ = 25;
  localparam int UFB_REF_MHZ = 24;
  localparam int UFB_PREDIV_DEN = 13;
  localparam int UFB_PREDIV_NUM_FRAC = 8;
  localparam int UFB_OVERSAMPLE = 16;
  localparam int UFB_CHAR_BITS = 10;
  localparam int UFB_TIMEOUT_CHARS = 4;
  localparam logic [9:0] UFB_TIMEOUT_TICKS =
    10'(UFB_TIMEOUT_CHARS * UFB_CHAR_BITS * UFB_OVERSAMPLE);
endpackage

//--- core/ufb_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module ufb_fifo
  import ufb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic push,
  input wire logic [7:0] din,
  input wire logic pop,
  output logic [7:0] dout,
  output logic [4:0] count
);
  logic [7:0] mem [UFB_FIFO_DEPTH];
  logic [UFB_FIFO_AW-1:0] wp_q;
  logic [UFB_FIFO_AW-1:0] rp_q;
  logic [4:0] cnt_q;
  wire do_push = push && (cnt_q != UFB_FIFO_FULL);
  wire do_pop = pop && (cnt_q != 5'h00);

  assign dout = mem[rp_q];
  assign count = cnt_q;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp_q] <= din;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= 5'h00;
    end else begin
      wp_q <= wp_q + UFB_FIFO_AW'(do_push);
      rp_q <= rp_q + UFB_FIFO_AW'(do_pop);
      cnt_q <= cnt_q + 5'(do_push) - 5'(do_pop);
    end
  end
endmodule // ufb_fifo
`default_nettype wire

//--- core/ufb_baudgen.sv
`timescale 1ns/1ns
`default_nettype none
module ufb_baudgen
  import ufb_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] prediv_sel,
  input wire logic high_speed,
  input wire logic [15:0] divisor,
  output logic tick16
);
  // the 24 MHz reference is an enable made by a fractional accumulator
  logic [5:0] ref_acc_q;
  logic [4:0] pre_acc_q;
  logic [15:0] div_cnt_q;
  logic tick_q;
  wire [5:0] ref_sum = ref_acc_q + 6'(UFB_REF_MHZ);
  wire ref_en = ref_sum >= 6'(UFB_CLK_MHZ);
  // ratio 13 adds 1 of 13, ratio 1.625 adds 8 of 13, ratio 1.0 bypasses
  wire bypass = high_speed || (prediv_sel == 2'h2);
  wire [4:0] pre_num = (prediv_sel == 2'h1) ? 5'(UFB_PREDIV_NUM_FRAC) : 5'h01;
  wire [4:0] pre_sum = pre_acc_q + pre_num;
  wire pre_wrap = pre_sum >= 5'(UFB_PREDIV_DEN);
  wire pre_en = ref_en && (bypass || pre_wrap);
  // divisor zero stops the generator rather than dividing by 65536
  wire div_hit = pre_en && (divisor != 16'h0000) && (div_cnt_q <= 16'h0001);

  assign tick16 = tick_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_acc_q <= 6'h00;
      pre_acc_q <= 5'h00;
      div_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      ref_acc_q <= ref_en ? ref_sum - 6'(UFB_CLK_MHZ) : ref_sum;
      if (ref_en) begin
        pre_acc_q <= pre_wrap ? pre_sum - 5'(UFB_PREDIV_DEN) : pre_sum;
      end
      if (div_hit) begin
        div_cnt_q <= divisor;
      end else if (pre_en && div_cnt_q != 16'h0000) begin
        div_cnt_q <= div_cnt_q - 16'h0001;
      end
      tick_q <= div_hit;
    end
  end
endmodule // ufb_baudgen
`default_nettype wire

//--- bench/ufb_uart_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ufb_uart_chk
  import ufb_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic IRQ,
  input wire logic DMA_MODE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the host-written registers, rebuilt from bus traffic
  logic r_q, w_q, dlab_q, fen_q, dma_q;
  logic [7:0] a_q, scr_q;
  logic [3:0] ien_q;
  wire take = HSEL & HTRANS[1] & HREADY;
  wire rd_id = r_q && a_q == UFB_A_IIR;
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      {r_q, w_q, dlab_q, fen_q, dma_q} <= 5'h00;
      a_q <= 8'h00;
      scr_q <= 8'h00;
      ien_q <= 4'h0;
    end else begin
      r_q <= take & ~HWRITE;
      w_q <= take & HWRITE;
      if (take) a_q <= HADDR[7:0];
      if (w_q && a_q == UFB_A_LCR) dlab_q <= HWDATA[UFB_LC_DLAB];
      if (w_q && a_q == UFB_A_IER && !dlab_q) ien_q <= HWDATA[3:0];
      if (w_q && a_q == UFB_A_SCR) scr_q <= HWDATA[7:0];
      if (w_q && a_q == UFB_A_IIR) fen_q <= HWDATA[UFB_FC_FIFO_EN];
      if (w_q && a_q == UFB_A_IIR) dma_q <= HWDATA[0] & HWDATA[UFB_FC_DMA];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_id_top; rd_id |-> HRDATA[7:6] == {2{fen_q}}; endproperty
  a_id_top: assert property (p_id_top)
    else $error("ident top bits do not follow fifo mode");
  property p_id_zero; rd_id |-> HRDATA[5:4] == 2'h0; endproperty
  a_id_zero: assert property (p_id_zero)
    else $error("ident bits 5 and 4 not zero");
  property p_id_to; rd_id && !fen_q |-> !HRDATA[3]; endproperty
  a_id_to: assert property (p_id_to)
    else $error("ident bit 3 set outside fifo mode");
  property p_id_none;
    rd_id |-> HRDATA[0] == (HRDATA[3:0] == UFB_IID_NONE);
  endproperty
  a_id_none: assert property (p_id_none)
    else $error("ident bit 0 disagrees with reported code");
  property p_ien;
    r_q && a_q == UFB_A_IER && !dlab_q |-> HRDATA[7:0] == {4'h0, ien_q};
  endproperty
  a_ien: assert property (p_ien)
    else $error("interrupt enable readback wrong");
  property p_quiet; (ien_q == 4'h0) [*3] |-> !IRQ; endproperty
  a_quiet: assert property (p_quiet)
    else $error("interrupt raised with all enables off");
  property p_dma;
    w_q && a_q == UFB_A_IIR |-> ##2 DMA_MODE == dma_q;
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma mode does not follow fifo control");
  property p_scr;
    r_q && a_q == UFB_A_SCR |-> HRDATA == {24'h0, scr_q};
  endproperty
  a_scr: assert property (p_scr)
    else $error("scratch readback wrong");
endmodule // ufb_uart_chk
bind ufb_uart ufb_uart_chk i_ufb_uart_chk (
  .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
  .HRDATA(HRDATA), .IRQ(IRQ), .DMA_MODE(DMA_MODE));
`default_nettype wire

//--- bench/ufb_term.sv
`timescale 1ns/1ns
`default_nettype none
module ufb_term
(
  output var logic sin,
  input wire logic sout,
  output var logic cts_n,
  output var logic dsr_n,
  output var logic ri_n,
  output var logic dcd_n
);
  // one bit is sixteen generator ticks; set by the bench per prescale
  int bit_ns = 667;
  logic [7:0] rx_q [$];
  initial begin
    sin = 1'b1;
    {dcd_n, ri_n, dsr_n, cts_n} = 4'hf;
  end
  // stop low with data zero makes a break; one idle bit follows
  // nonblocking, so a change in a clock edge's time step lands after it
  task automatic send(input logic [7:0] d, input logic stop);
    sin <= 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++) begin
      sin <= d[i];
      #(bit_ns);
    end
    sin <= stop;
    #(bit_ns);
    sin <= 1'b1;
    #(bit_ns);
  endtask
  task automatic modem(input logic [3:0] v);
    {dcd_n, ri_n, dsr_n, cts_n} <= v;
  endtask
  // mid-bit sampling, lsb first; a glitch shorter than half a bit is ignored
  always begin : rx
    logic [7:0] b;
    @(negedge sout);
    #(bit_ns / 2);
    if (sout == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        #(bit_ns);
        b[i] = sout;
      end
      #(bit_ns);
      rx_q.push_back(b);
    end
  end
endmodule // ufb_term
`default_nettype wire

//--- bench/ufb_uart_test.sv
`timescale 1ns/1ns
`default_nettype none
module ufb_uart_test
  import ufb_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hready, sin, sout, cts_n, dsr_n, ri_n, dcd_n, irq, dma;
  wire hresp, rts_n, dtr_n;
  int err_count = 0;
  int total_checks = 0;
  logic [7:0] cfg_v [4] = '{8'h04, 8'h02, 8'h01, 8'h00};
  int bit_v [4] = '{667, 667, 1083, 8667};
  int thr_v [4] = '{1, 4, 8, 14};
  always #20 clk = ~clk;
  ufb_uart i_ufb_uart (.CLK_SYS(clk), .RESET_N(rst_n), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .SIN(sin), .SOUT(sout), .CTS_N(cts_n), .DSR_N(dsr_n),
    .RI_N(ri_n), .DCD_N(dcd_n), .RTS_N(rts_n), .DTR_N(dtr_n), .IRQ(irq),
    .DMA_MODE(dma));
  ufb_term i_ufb_term (.sin(sin), .sout(sout), .cts_n(cts_n),
    .dsr_n(dsr_n), .ri_n(ri_n), .dcd_n(dcd_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      $display("BAD %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, {24'h0, d}, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, {24'h0, e}, r);
  endtask
  task automatic settle;
    repeat (3) @(negedge clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #(40 * 40000);
    err_count++;
    $display("BAD watchdog expected done seen hang");
    results;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] v;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc(UFB_A_IIR, 8'h01, "ident");
    rc(UFB_A_IER, 8'h00, "enable");
    chk("dma", 32'h0, {31'h0, dma});
    wr(UFB_A_SCR, 8'ha5);
    wr(8'h40, 8'hff);
    rc(8'h40, 8'h00, "unmapped");
    chk("hresp", 32'h0, {31'h0, hresp});
    rc(UFB_A_SCR, 8'ha5, "scratch");
    wr(UFB_A_IER, 8'hff);
    rc(UFB_A_IER, 8'h0f, "enable");
    rc(UFB_A_IIR, 8'h02, "ident");
    rc(UFB_A_IIR, 8'h01, "ident");
    wr(UFB_A_HC, 8'h08);
    wr(UFB_A_IER, 8'h00);
    $display("test registers done");
    wr(UFB_A_IIR, 8'h01);
    rc(UFB_A_IIR, 8'hc1, "ident");
    wr(UFB_A_IIR, 8'h09);
    settle;
    chk("dma", 32'h1, {31'h0, dma});
    wr(UFB_A_IIR, 8'h08);
    settle;
    chk("dma", 32'h0, {31'h0, dma});
    rc(UFB_A_IIR, 8'h01, "ident");
    wr(UFB_A_IIR, 8'h01);
    $display("test fifo mode done");
    // divisor still zero, so queued bytes stay put
    wr(UFB_A_DATA, 8'h55);
    wr(UFB_A_IER, 8'h02);
    rc(UFB_A_IIR, 8'hc1, "ident");
    wr(UFB_A_IIR, 8'h05);
    settle;
    chk("irq", 32'h1, {31'h0, irq});
    wr(UFB_A_IER, 8'h00);
    settle;
    chk("irq", 32'h0, {31'h0, irq});
    wr(UFB_A_IER, 8'h02);
    rc(UFB_A_IIR, 8'hc2, "ident");
    wr(UFB_A_DATA, 8'h66);
    rc(UFB_A_IIR, 8'hc1, "ident");
    wr(UFB_A_IIR, 8'h05);
    rc(UFB_A_IIR, 8'hc2, "ident");
    wr(UFB_A_IER, 8'h00);
    $display("test tx reset done");
    wr(UFB_A_LCR, 8'h80);
    wr(UFB_A_DATA, 8'h01);
    wr(UFB_A_IER, 8'h00);
    wr(UFB_A_LCR, 8'h00);
    for (int k = 0; k < 4; k++) begin
      i_ufb_term.bit_ns = bit_v[k];
      wr(UFB_A_CFG, cfg_v[k]);
      wr(UFB_A_DATA, 8'h3c + 8'(k));
      for (int t = 0; t < 4000 && i_ufb_term.rx_q.size() == 0; t++)
        @(posedge clk);
      v = i_ufb_term.rx_q.size() > 0 ? {24'h0, i_ufb_term.rx_q.pop_front()}
        : 32'hffff_ffff;
      chk("serial", 32'h3c + 32'(k), v);
    end
    wr(UFB_A_CFG, 8'h04);
    i_ufb_term.bit_ns = 667;
    $display("test baud done");
    wr(UFB_A_IER, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(UFB_A_IIR, 8'(k * 64 + 3));
      for (int i = 0; i < thr_v[k] - 1; i++) begin
        i_ufb_term.send(8'h10 + 8'(i), 1'b1);
      end
      rc(UFB_A_IIR, 8'hc1, "below level");
      i_ufb_term.send(8'h10 + 8'(thr_v[k] - 1), 1'b1);
      rc(UFB_A_IIR, 8'hc4, "at level");
    end
    settle;
    chk("irq", 32'h1, {31'h0, irq});
    rc(UFB_A_DATA, 8'h10, "rx data");
    rc(UFB_A_IIR, 8'hc1, "ident");
    repeat (800) @(posedge clk);
    rc(UFB_A_IIR, 8'hcc, "timeout");
    rc(UFB_A_DATA, 8'h11, "rx data");
    rc(UFB_A_IIR, 8'hc1, "ident");
    $display("test receive done");
    wr(UFB_A_IIR, 8'h03);
    wr(UFB_A_IER, 8'h05);
    i_ufb_term.send(8'h00, 1'b0);
    rc(UFB_A_IIR, 8'hc6, "ident");
    bus(1'b0, UFB_A_LSR, 32'h0, v);
    chk("line status", 32'h18, v & 32'h18);
    rc(UFB_A_IIR, 8'hc4, "ident");
    rc(UFB_A_DATA, 8'h00, "rx data");
    rc(UFB_A_IIR, 8'hc1, "ident");
    $display("test line status done");
    wr(UFB_A_IER, 8'h08);
    i_ufb_term.modem(4'he);
    settle;
    rc(UFB_A_IIR, 8'hc0, "ident");
    bus(1'b0, UFB_A_HSR, 32'h0, v);
    chk("handshake", 32'h11, v & 32'h1f);
    rc(UFB_A_IIR, 8'hc1, "ident");
    i_ufb_term.modem(4'ha);
    settle;
    i_ufb_term.modem(4'he);
    settle;
    bus(1'b0, UFB_A_HSR, 32'h0, v);
    chk("ring edge", 32'h04, v & 32'h0f);
    wr(UFB_A_HC, 8'h0b);
    settle;
    chk("rts", 32'h0, {31'h0, rts_n});
    chk("dtr", 32'h0, {31'h0, dtr_n});
    // loopback: modem outputs idle, handshake bits fed from the control bits
    wr(UFB_A_HC, 8'h1b);
    settle;
    chk("loop rts", 32'h1, {31'h0, rts_n});
    chk("loop dtr", 32'h1, {31'h0, dtr_n});
    bus(1'b0, UFB_A_HSR, 32'h0, v);
    chk("loop handshake", 32'hba, v);
    wr(UFB_A_DATA, 8'h5a);
    repeat (300) @(posedge clk);
    rc(UFB_A_DATA, 8'h5a, "loop data");
    chk("quiet line", 32'h0, 32'(i_ufb_term.rx_q.size()));
    $display("test handshake done");
    results;
  end
endmodule // ufb_uart_test
`default_nettype wire
